// ---- mcsm_pkg.sv ----
package mcsm_pkg;

   // ***************************************************************
   // Register map and bus answers
   // ***************************************************************
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] OFF_CMD      = 8'h00;
   localparam logic [7:0] OFF_PARAMS   = 8'h04;
   localparam logic [7:0] OFF_SAFE     = 8'h08;
   localparam logic [7:0] OFF_STATUS   = 8'h0c;
   localparam logic [7:0] OFF_POSITION = 8'h10;
   localparam logic [7:0] OFF_SEARCH   = 8'h14;
   localparam logic [7:0] OFF_ARG      = 8'h18;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // ***************************************************************
   // Command codes, written to the low nibble of the command register
   // ***************************************************************
   localparam logic [3:0] CMD_MOVE_TO_TARGET  = 4'h1;
   localparam logic [3:0] CMD_GO_SAFE         = 4'h2;
   localparam logic [3:0] CMD_REFERENCE       = 4'h3;
   localparam logic [3:0] CMD_ZERO_POSITION   = 4'h4;
   localparam logic [3:0] CMD_RELOAD_DEFAULTS = 4'h5;
   localparam logic [3:0] CMD_IMMEDIATE_HALT  = 4'h6;
   localparam logic [3:0] CMD_DECEL_HALT      = 4'h7;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_VMIN_LSB = 8;
   localparam int CMD_VMAX_LSB = 12;
   localparam int CMD_POS_LSB  = 16;
   localparam int ARG_POS1_LSB = 0;
   localparam int ARG_POS2_LSB = 16;
   localparam int PAR_W        = 24;
   localparam int PAR_VMIN_LSB = 8;
   localparam int PAR_VMAX_LSB = 12;
   localparam int PAR_ACC_LSB  = 17;
   localparam int PAR_SHAPE    = 21;
   localparam int POS_W        = 16;
   localparam int SAFE_W       = 11;
   localparam int SAFE_PAD_W   = 5;
   localparam logic [10:0] SAFE_NONE = 11'h400;

   // ***************************************************************
   // Synchronised pin vector
   // ***************************************************************
   localparam int PIN_TSD   = 0;
   localparam int PIN_UV2   = 1;
   localparam int PIN_CPF   = 2;
   localparam int PIN_ELD   = 3;
   localparam int PIN_OVC   = 4;
   localparam int PIN_DIP   = 5;
   localparam int PIN_STEP  = 6;
   localparam int NUM_PINS  = 7;

   typedef enum logic [2:0] {
      MCSM_OFF, MCSM_STOPPED, MCSM_MOVING, MCSM_SEARCH, MCSM_DECEL, MCSM_IMMEDIATE
   } mcsm_state_t;

endpackage

// ---- mcsm_core.sv ----
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module mcsm_core
   import mcsm_pkg::*;
#(
   parameter logic [23:0] OTP_PARAMS  = 24'h000000,
   parameter logic [10:0] OTP_SAFE    = 11'h400,
   parameter int          DECEL_STEPS = 4
) (
   // Clock, reset and enable
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   // Register bus
   input  wire logic [mcsm_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [mcsm_pkg::ADDR_W-1:0] araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // Pins from the motor side
   input  wire logic                  step_clk,
   input  wire logic                  tsd_cond,
   input  wire logic                  undervoltage_cutoff_flag,
   input  wire logic                  pump_fail_cond,
   input  wire logic                  eldefect_cond,
   input  wire logic                  overcurrent_cond,
   input  wire logic                  supply_dip,
   // Drive outputs
   output logic [2:0]                 motion_state,
   output logic                       ramp_shape_out,
   output logic [3:0]                 drive_vmax,
   output logic [3:0]                 drive_vmin,
   output logic [3:0]                 drive_acc,
   output logic                       safe_valid
);
   import mcsm_pkg::*;

   // The halt counter is eight bits wide and must see at least one slot.
   if (DECEL_STEPS < 1 || DECEL_STEPS > 255) begin : g_bad_decel
      $error("DECEL_STEPS must lie in 1..255.");
   end

   localparam logic [7:0] DECEL_CNT = 8'(DECEL_STEPS);

   typedef struct packed {
      mcsm_state_t          state;
      logic                 search_second;
      logic [7:0]           halt_cnt;
      logic [POS_W-1:0]     current_position;
      logic [POS_W-1:0]     target_position;
      logic [POS_W-1:0]     search_target;
      logic [POS_W-1:0]     search_pos2;
      logic [PAR_W-1:0]     ram;
      logic [PAR_W-1:0]     search_par;
      logic [SAFE_W-1:0]    safe_position;
      logic                 tsd;
      logic                 forced_halt_flag;
      logic                 step_loss;
      logic                 supply_glitch_flag;
      logic                 ovc;
      logic                 stop_flag;
      logic [NUM_PINS-1:0]  pin_m;
      logic [NUM_PINS-1:0]  pin_s;
      logic                 step_prev;
      logic [31:0]          cmd_arg;
      logic                 awready;
      logic                 wready;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 arready;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      logic [2:0]           out_state;
      logic                 out_shape;
      logic [3:0]           out_vmax;
      logic [3:0]           out_vmin;
      logic [3:0]           out_acc;
      logic                 out_safe_valid;
   } mcsm_regs_t;

   mcsm_regs_t st;
   mcsm_regs_t next_st;

   logic              wr_go;
   logic              rd_go;
   logic              full_status_read_cmd;
   logic              cmd_fire;
   logic [3:0]        cmd_code;
   logic              step_edge;
   logic              hard_fault;
   logic              move_ok;
   logic              safe_ok;
   logic              imm_cmd;
   logic              decel_cmd;
   logic [POS_W-1:0]  motion_target;
   logic [POS_W-1:0]  safe_target;
   logic [PAR_W-1:0]  eff_par;

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   always_comb begin
      next_st   = st;
      wr_go     = awvalid && wvalid && st.awready && st.wready;
      rd_go     = arvalid && st.arready;
      full_status_read_cmd = rd_go && araddr == OFF_STATUS;
      cmd_fire  = wr_go && awaddr == OFF_CMD;
      cmd_code  = wdata[CMD_CODE_LSB +: 4];
      step_edge = st.pin_s[PIN_STEP] && !st.step_prev;
      hard_fault = st.pin_s[PIN_CPF] || st.pin_s[PIN_UV2] || st.pin_s[PIN_ELD];
      imm_cmd   = cmd_fire && cmd_code == CMD_IMMEDIATE_HALT;
      decel_cmd = cmd_fire && cmd_code == CMD_DECEL_HALT;
      move_ok   = cmd_fire && cmd_code == CMD_MOVE_TO_TARGET && !st.step_loss;
      safe_ok   = cmd_fire && cmd_code == CMD_GO_SAFE && !st.step_loss && st.out_safe_valid;
      safe_target   = {st.safe_position, SAFE_PAD_W'(0)};
      motion_target = (st.state == MCSM_SEARCH) ? st.search_target : st.target_position;

      // Pin synchronisers; only the second stage is looked at.
      next_st.pin_m     = {step_clk, supply_dip, overcurrent_cond, eldefect_cond,
                           pump_fail_cond, undervoltage_cutoff_flag, tsd_cond};
      next_st.pin_s     = st.pin_m;
      next_st.step_prev = st.pin_s[PIN_STEP];

      // Set wins over the read that clears, so a fault still present stays flagged.
      next_st.tsd = st.pin_s[PIN_TSD] || (st.tsd && !full_status_read_cmd);
      next_st.forced_halt_flag = hard_fault || (st.forced_halt_flag && !full_status_read_cmd);
      next_st.ovc = st.pin_s[PIN_OVC] || (st.ovc && !full_status_read_cmd);
      next_st.supply_glitch_flag = st.pin_s[PIN_DIP]
                                   || (st.supply_glitch_flag && !full_status_read_cmd);
      next_st.step_loss = st.pin_s[PIN_UV2] || st.pin_s[PIN_OVC] || st.pin_s[PIN_TSD]
                          || (st.step_loss && !full_status_read_cmd);

      // Working parameters; motion consistency is the host's concern.
      if (wr_go && awaddr == OFF_PARAMS) begin
         for (int b = 0; b < PAR_W / 8; b++) begin
            if (wstrb[b]) begin
               next_st.ram[b*8 +: 8] = wdata[b*8 +: 8];
            end
         end
      end
      if (wr_go && awaddr == OFF_SAFE && wstrb[0] && wstrb[1]) begin
         next_st.safe_position = wdata[SAFE_W-1:0];
      end
      if (wr_go && awaddr == OFF_ARG) begin
         next_st.cmd_arg = wdata;
      end
      if (cmd_fire && cmd_code == CMD_RELOAD_DEFAULTS) begin
         next_st.ram = OTP_PARAMS;
         next_st.ram[PAR_SHAPE] = 1'b0;
         next_st.safe_position = OTP_SAFE;
      end

      // Stepping toward the active target while the motor is driven.
      if (step_edge && st.current_position != motion_target && (st.state == MCSM_MOVING
          || st.state == MCSM_SEARCH || st.state == MCSM_DECEL)) begin
         if ($signed(motion_target) > $signed(st.current_position)) begin
            next_st.current_position = st.current_position + POS_W'(1);
         end else begin
            next_st.current_position = st.current_position - POS_W'(1);
         end
      end

      // Target updates that do not change state.
      if (st.state == MCSM_STOPPED || st.state == MCSM_MOVING || st.state == MCSM_SEARCH) begin
         if (move_ok) begin
            next_st.target_position = wdata[CMD_POS_LSB +: POS_W];
         end else if (safe_ok) begin
            next_st.target_position = safe_target;
         end
      end
      if (cmd_fire && cmd_code == CMD_ZERO_POSITION
          && (st.state == MCSM_STOPPED || st.state == MCSM_OFF)) begin
         next_st.current_position = '0;
         next_st.target_position  = '0;
      end

      case (st.state)
         MCSM_OFF: begin
            if (full_status_read_cmd && !next_st.tsd && !next_st.forced_halt_flag) begin
               next_st.state = MCSM_STOPPED;
            end
         end
         MCSM_STOPPED: begin
            next_st.stop_flag = 1'b0;
            if (st.forced_halt_flag || st.tsd) begin
               next_st.state = MCSM_OFF;
            end else if (st.stop_flag) begin
               next_st.state = MCSM_STOPPED;
            end else if (cmd_fire && cmd_code == CMD_REFERENCE) begin
               next_st.state = MCSM_SEARCH;
               next_st.search_second = 1'b0;
               next_st.search_par = st.ram;
               next_st.search_par[PAR_VMIN_LSB +: 4] = wdata[CMD_VMIN_LSB +: 4];
               next_st.search_par[PAR_VMAX_LSB +: 4] = wdata[CMD_VMAX_LSB +: 4];
               next_st.search_target = st.cmd_arg[ARG_POS1_LSB +: POS_W];
               next_st.search_pos2   = st.cmd_arg[ARG_POS2_LSB +: POS_W];
            end else if (move_ok || safe_ok) begin
               next_st.state = MCSM_MOVING;
            end else if (st.current_position != st.target_position) begin
               next_st.state = MCSM_MOVING;
            end
         end
         MCSM_MOVING, MCSM_SEARCH: begin
            if (imm_cmd || st.forced_halt_flag) begin
               next_st.state = MCSM_IMMEDIATE;
            end else if ((decel_cmd && st.state == MCSM_MOVING) || st.tsd) begin
               next_st.state = MCSM_DECEL;
               next_st.halt_cnt = DECEL_CNT;
            end else if (st.current_position == motion_target) begin
               if (st.state == MCSM_MOVING) begin
                  next_st.state = MCSM_STOPPED;
               end else if (!st.search_second) begin
                  next_st.search_second = 1'b1;
                  next_st.search_target = st.search_pos2;
               end else begin
                  next_st.search_second = 1'b0;
                  next_st.current_position = '0;
                  if (st.out_safe_valid && !st.step_loss) begin
                     next_st.target_position = safe_target;
                     next_st.state = MCSM_MOVING;
                  end else begin
                     next_st.state = MCSM_STOPPED;
                  end
               end
            end
         end
         MCSM_DECEL: begin
            if (imm_cmd || st.forced_halt_flag) begin
               next_st.state = MCSM_IMMEDIATE;
            end else if (st.halt_cnt == 8'h00) begin
               next_st.state = MCSM_STOPPED;
               next_st.target_position = st.current_position;
               next_st.stop_flag = 1'b1;
            end else if (step_edge) begin
               next_st.halt_cnt = st.halt_cnt - 8'h01;
            end
         end
         MCSM_IMMEDIATE: begin
            // The coils are held; the next step slot marks the motor at rest.
            if (step_edge) begin
               next_st.state = MCSM_STOPPED;
               next_st.target_position = st.current_position;
               next_st.stop_flag = 1'b1;
            end
         end
         default: begin
            next_st.state = MCSM_OFF;
         end
      endcase
      if (imm_cmd && (st.state == MCSM_MOVING || st.state == MCSM_SEARCH
          || st.state == MCSM_DECEL)) begin
         next_st.step_loss = 1'b1;
      end

      // ***************************************************************
      // Bus slave: address and data are taken together
      // ***************************************************************
      next_st.awready = 1'b0;
      next_st.wready  = 1'b0;
      next_st.arready = 1'b0;
      if (awvalid && wvalid && !st.awready && !st.bvalid) begin
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_st.bvalid = 1'b1;
         next_st.bresp  = (awaddr == OFF_CMD || awaddr == OFF_PARAMS || awaddr == OFF_SAFE
                           || awaddr == OFF_ARG) ? RESP_OKAY : RESP_SLVERR;
      end
      if (arvalid && !st.arready && !st.rvalid) begin
         next_st.arready = 1'b1;
      end
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (rd_go) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OKAY;
         case (araddr)
            OFF_PARAMS:   next_st.rdata = {8'h00, st.ram};
            OFF_SAFE:     next_st.rdata = {21'h000000, st.safe_position};
            OFF_STATUS:   next_st.rdata = {8'h00, st.ram[PAR_VMAX_LSB +: 4],
                                           st.ram[PAR_VMIN_LSB +: 4], 5'h00,
                                           st.search_second, st.ovc, st.out_safe_valid,
                                           st.stop_flag, st.forced_halt_flag, st.tsd,
                                           st.step_loss, st.supply_glitch_flag, st.state};
            OFF_POSITION: next_st.rdata = {st.target_position, st.current_position};
            OFF_SEARCH:   next_st.rdata = {8'h00, st.search_par};
            OFF_ARG:      next_st.rdata = st.cmd_arg;
            default: begin
               next_st.rdata = 32'h00000000;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Registered drive outputs follow the active parameter set.
      eff_par = (next_st.state == MCSM_SEARCH) ? next_st.search_par : next_st.ram;
      next_st.out_state = next_st.state;
      next_st.out_shape = eff_par[PAR_SHAPE]
                          || (next_st.state == MCSM_SEARCH && next_st.search_second);
      next_st.out_vmax = eff_par[PAR_VMAX_LSB +: 4];
      next_st.out_vmin = eff_par[PAR_VMIN_LSB +: 4];
      next_st.out_acc  = eff_par[PAR_ACC_LSB +: 4];
      next_st.out_safe_valid = next_st.safe_position != SAFE_NONE;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.state <= MCSM_OFF;
         st.ram <= OTP_PARAMS;
         st.safe_position <= OTP_SAFE;
         st.supply_glitch_flag <= 1'b1;
         st.out_vmax <= OTP_PARAMS[PAR_VMAX_LSB +: 4];
         st.out_vmin <= OTP_PARAMS[PAR_VMIN_LSB +: 4];
         st.out_acc <= OTP_PARAMS[PAR_ACC_LSB +: 4];
         st.out_shape <= OTP_PARAMS[PAR_SHAPE];
         st.out_safe_valid <= OTP_SAFE != SAFE_NONE;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign awready        = st.awready;
   assign wready         = st.wready;
   assign bvalid         = st.bvalid;
   assign bresp          = st.bresp;
   assign arready        = st.arready;
   assign rvalid         = st.rvalid;
   assign rdata          = st.rdata;
   assign rresp          = st.rresp;
   assign motion_state   = st.out_state;
   assign ramp_shape_out = st.out_shape;
   assign drive_vmax     = st.out_vmax;
   assign drive_vmin     = st.out_vmin;
   assign drive_acc      = st.out_acc;
   assign safe_valid     = st.out_safe_valid;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_off_after_reset: assert property ($past(!aresetn) |-> st.state == MCSM_OFF)
      else $error("State is not off after reset.");
   a_off_exit_cause: assert property ($past(st.state) == MCSM_OFF && st.state != MCSM_OFF
      |-> $past(full_status_read_cmd) && !st.tsd && !st.forced_halt_flag)
      else $error("Off state left without read or with flags set.");
   a_step_loss_hold: assert property ($past(st.step_loss) && !st.step_loss
      |-> $past(full_status_read_cmd))
      else $error("Step loss cleared without a status read.");
   a_target_blocked: assert property (ce && st.step_loss && cmd_fire
      && (cmd_code == CMD_MOVE_TO_TARGET || cmd_code == CMD_GO_SAFE)
      && st.state != MCSM_DECEL && st.state != MCSM_IMMEDIATE
      |=> $stable(st.target_position))
      else $error("Target changed while step loss set.");
   a_imm_priority: assert property (ce && imm_cmd && st.state == MCSM_MOVING
      |=> st.state == MCSM_IMMEDIATE && st.step_loss)
      else $error("Immediate halt not taken first.");
   a_thermal_decel: assert property (ce && st.tsd && !imm_cmd && !st.forced_halt_flag
      && st.state == MCSM_MOVING |=> st.state == MCSM_DECEL)
      else $error("Thermal flag did not start a decelerating halt.");
   a_search_entry: assert property (st.state == MCSM_SEARCH
      && $past(st.state) != MCSM_SEARCH |-> $past(st.state) == MCSM_STOPPED)
      else $error("Search entered from a state other than stopped.");
   a_shape_forced: assert property (ce && next_st.state == MCSM_SEARCH
      && next_st.search_second |=> ramp_shape_out)
      else $error("Ramp shape not forced in second search motion.");
   a_stop_flag_set: assert property ($past(st.state) inside {MCSM_DECEL, MCSM_IMMEDIATE}
      && st.state == MCSM_STOPPED |-> st.stop_flag ##1 (!ce || !st.stop_flag))
      else $error("Stop flag wrong around halt exit.");
   a_safe_valid: assert property (ce |=>
      safe_valid == ($past(next_st.safe_position) != SAFE_NONE))
      else $error("Safe valid disagrees with safe position.");

endmodule // mcsm_core

// ---- mcsm_motor_side.sv ----
`timescale 1ns/10ps
module mcsm_motor_side (
   // Bench control
   input  wire logic hot,
   // Pins towards the core
   output logic      step_clk,
   output logic      tsd_cond
);
   // Slots run free, so moves never stall waiting for a slot.
   initial begin
      step_clk = 1'b0;
      forever #80 step_clk = ~step_clk;
   end
   assign tsd_cond = hot;
endmodule // mcsm_motor_side

// ---- motion_command_state_machine_tb.sv ----
`timescale 1ns/10ps
module motion_command_state_machine_tb;
   import mcsm_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hot, overcurrent_cond;
   logic awready, wready, bvalid, arready, rvalid, step_clk, tsd_cond, safe_valid;
   logic ramp_shape_out, pump_fail_cond;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, r;
   logic [3:0]  wstrb, drive_vmax, drive_vmin, drive_acc;
   logic [1:0]  bresp, rresp, rs;
   logic [2:0]  motion_state;
   logic [15:0] tgt;
   int          mismatches, num_checks, k;
   wire logic   ce = 1'b1, eldefect_cond = 1'b0;
   wire logic   supply_dip = 1'b0, undervoltage_cutoff_flag = 1'b0;
   mcsm_core #(.DECEL_STEPS(2)) mcsm_core_inst (.aclk, .aresetn, .ce, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .step_clk, .tsd_cond,
      .undervoltage_cutoff_flag, .pump_fail_cond, .eldefect_cond, .overcurrent_cond,
      .supply_dip, .motion_state, .ramp_shape_out, .drive_vmax, .drive_vmin,
      .drive_acc, .safe_valid);
   mcsm_motor_side mcsm_motor_side_inst (.hot, .step_clk, .tsd_cond);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("mismatches %0d, checks %0d", mismatches, num_checks);
      if (mismatches == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task tmo(input int n);
      if (n >= 4000) begin
         mismatches++;
         wrap_up();
      end
   endtask
   // Ready lines are held high, which the bus permits, so no pulse is re-armed.
   task wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 4000);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 4000);
      chk(bresp, RESP_OKAY);
      tmo(n);
   endtask
   task rd(input logic [7:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 4000);
      arvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 4000);
      r = rdata;
      rs = rresp;
      tmo(n);
   endtask
   task wait_st(input logic [2:0] s);
      int n;
      n = 0;
      do begin @(posedge aclk); n++; end while (motion_state !== s && n < 4000);
      chk(motion_state, s);
      if (motion_state !== s) wrap_up();
   endtask
   initial begin
      {aresetn, awvalid, wvalid, arvalid, hot, overcurrent_cond, pump_fail_cond} = 7'h00;
      {bready, rready, wstrb, awaddr, araddr, wdata} = {2'h3, 4'hf, 48'h0};
      mismatches = 0;
      num_checks = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFF_STATUS);
      chk({r[8], r[3], r[2:0]}, 5'h08);
      wait_st(MCSM_STOPPED);
      rd(OFF_STATUS);
      chk(r[3], 1'b0);
      wr(OFF_SAFE, 32'h1);
      @(posedge aclk);
      chk(safe_valid, 1'b1);
      wr(OFF_PARAMS, 32'h0031a5);
      rd(OFF_PARAMS);
      chk(r[23:0], 24'h0031a5);
      wr(OFF_ARG, 32'h00060008);
      wr(OFF_CMD, 32'h6503);
      wait_st(MCSM_SEARCH);
      rd(OFF_STATUS);
      chk(r[23:16], 8'h31);
      chk(drive_vmin, 4'h5);
      chk(drive_vmax, 4'h6);
      chk(drive_acc, 4'h0);
      wr(OFF_PARAMS, 32'h0097a5);
      chk(drive_vmin, 4'h5);
      k = 0;
      do begin rd(OFF_POSITION); k++; end while (r[15:0] !== 16'h0008 && k < 200);
      if (k >= 200) tmo(4000);
      rd(OFF_STATUS);
      chk(r[10], 1'b1);
      chk(ramp_shape_out, 1'b1);
      wait_st(MCSM_STOPPED);
      chk(drive_vmin, 4'h7);
      chk(ramp_shape_out, 1'b0);
      rd(OFF_POSITION);
      chk(r, 32'h00200020);
      wr(OFF_CMD, 32'h01000001);
      wait_st(MCSM_MOVING);
      // Halt right after a step slot, so the halted state stands until the next slot.
      k = 0;
      do begin @(posedge aclk); k++; end while (step_clk !== 1'b0 && k < 100);
      do begin @(posedge aclk); k++; end while (step_clk !== 1'b1 && k < 100);
      if (k >= 100) tmo(4000);
      wr(OFF_CMD, 32'h6);
      wait_st(MCSM_IMMEDIATE);
      wait_st(MCSM_STOPPED);
      rd(OFF_POSITION);
      chk(r[15:0], r[31:16]);
      tgt = r[31:16];
      wr(OFF_CMD, 32'h02000001);
      rd(OFF_POSITION);
      chk(r[31:16], tgt);
      chk(motion_state, MCSM_STOPPED);
      wr(OFF_CMD, 32'h4);
      rd(OFF_POSITION);
      chk(r, 32'h0);
      rd(OFF_STATUS);
      chk(r[4], 1'b1);
      rd(OFF_STATUS);
      chk(r[4], 1'b0);
      hot <= 1'b1;
      wait_st(MCSM_OFF);
      rd(OFF_STATUS);
      chk(r[5], 1'b1);
      repeat (4) @(posedge aclk);
      chk(motion_state, MCSM_OFF);
      hot <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(OFF_STATUS);
      wait_st(MCSM_STOPPED);
      wr(OFF_CMD, 32'h01000001);
      wait_st(MCSM_MOVING);
      wr(OFF_CMD, 32'h7);
      wait_st(MCSM_DECEL);
      wait_st(MCSM_STOPPED);
      rd(OFF_STATUS);
      chk(r[4], 1'b0);
      wr(OFF_CMD, 32'h01000001);
      wait_st(MCSM_MOVING);
      hot <= 1'b1;
      wait_st(MCSM_DECEL);
      wait_st(MCSM_OFF);
      hot <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(OFF_STATUS);
      wait_st(MCSM_STOPPED);
      wr(OFF_CMD, 32'h01000001);
      wait_st(MCSM_MOVING);
      pump_fail_cond <= 1'b1;
      wait_st(MCSM_IMMEDIATE);
      wait_st(MCSM_OFF);
      pump_fail_cond <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(OFF_STATUS);
      chk(r[6], 1'b1);
      wait_st(MCSM_STOPPED);
      wr(OFF_CMD, 32'h5);
      rd(OFF_PARAMS);
      chk(r, 32'h0);
      chk(safe_valid, 1'b0);
      overcurrent_cond <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(OFF_STATUS);
      chk({r[9], r[4], r[2:0]}, 5'h19);
      overcurrent_cond <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(OFF_STATUS);
      rd(OFF_STATUS);
      chk({r[9], r[4]}, 2'h0);
      rd(8'h40);
      chk(rs, RESP_SLVERR);
      chk(r, 32'h0);
      wrap_up();
   end
endmodule // motion_command_state_machine_tb
